//--- design/spi_port_pkg.sv
// Constants for the slave serial transaction port
package spi_port_pkg;

	// ------------------------------------------------------------
	// Register locations (SFR space and I/O RAM space)
	// ------------------------------------------------------------
	localparam logic [15:0] ADDR_INT_FLAG   = 16'h00F8;
	localparam logic [15:0] ADDR_CMD_CAP    = 16'h00FD;
	localparam logic [15:0] ADDR_INT_EN     = 16'h2701;
	localparam logic [15:0] ADDR_STATUS     = 16'h2708;
	localparam logic [15:0] ADDR_PORT_CTRL  = 16'h270C;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BIT_INT_FLAG   = 7;
	localparam int BIT_INT_EN     = 7;
	localparam int BIT_PORT_EN    = 4;
	localparam int BIT_GUARD      = 3;
	localparam int ST_READY_ERR   = 7;
	localparam int ST_RD_PARITY   = 6;
	localparam int ST_WR_PARITY   = 5;
	localparam int ST_CNT_HI      = 4;
	localparam int ST_CNT_LO      = 2;
	localparam int ST_FLASH_MODE  = 1;
	localparam int ST_FLASH_READY = 0;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic       RST_INT_FLAG  = 1'b0;
	localparam logic       RST_INT_EN    = 1'b0;
	localparam logic       RST_PORT_EN   = 1'b1;
	localparam logic       RST_GUARD     = 1'b0;
	localparam logic [7:0] RST_STATUS    = 8'h00;
	localparam logic [7:0] RST_CMD_CAP   = 8'h00;

	// ------------------------------------------------------------
	// Protocol values
	// ------------------------------------------------------------
	localparam logic [7:0]  CMD_QUIET_RD  = 8'h80;
	localparam logic [7:0]  CMD_QUIET_WR  = 8'h00;
	localparam logic [2:0]  SHORT_COUNT   = 3'h7;
	localparam logic [2:0]  HEADER_BYTES  = 3'h3;
	localparam logic [15:0] GUARD_LO      = 16'h0400;
	localparam logic [15:0] GUARD_HI      = 16'h040F;

endpackage : spi_port_pkg

//--- design/pin_sync.sv
// Two-flop synchroniser for a group of pin inputs
module pin_sync #(
	parameter int               WIDTH   = 4,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	// ------------------------------------------------------------
	// Per-bit synchroniser
	// ------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta_reg;
			logic sync_reg;
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					meta_reg <= RST_VAL[i];
					sync_reg <= RST_VAL[i];
				end else if (ce) begin
					meta_reg <= d[i];
					sync_reg <= meta_reg;
				end
			end
			assign q[i] = sync_reg;
		end
	endgenerate

endmodule : pin_sync

//--- design/spi_slave_transaction_port.sv
// Slave serial port giving an external host access to memory and commands
module spi_slave_transaction_port (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	input  wire logic        select_low_pin,
	input  wire logic        serial_clock_pin,
	input  wire logic        serial_data_in_pin,
	output logic             serial_data_out,
	output logic             serial_data_out_oe,
	output logic             shared_pins_spi_sel,
	input  wire logic        test_pin,
	input  wire logic        flash_programming_mode,
	input  wire logic        flash_write_ready,
	input  wire logic        mpu_sfr_sel,
	input  wire logic [15:0] mpu_addr,
	input  wire logic        mpu_wr,
	input  wire logic [7:0]  mpu_wdata,
	output logic      [7:0]  mpu_rdata,
	output logic             mpu_irq,
	output logic             mem_req,
	output logic             mem_we,
	output logic      [15:0] mem_addr,
	output logic      [7:0]  mem_wdata,
	input  wire logic        mem_ack,
	input  wire logic [7:0]  mem_rdata
);
	import spi_port_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic        act;
		logic        sck_d;
		logic [2:0]  bit_cnt;
		logic [2:0]  byte_cnt;
		logic        multi;
		logic        data_ph;
		logic [7:0]  rx_sh;
		logic [7:0]  tx_sh;
		logic [7:0]  tx_byte;
		logic [15:0] addr;
		logic [7:0]  cmd;
		logic [7:0]  rd_buf;
		logic        rd_valid;
		logic        mem_req;
		logic        mem_we;
		logic [15:0] mem_addr;
		logic [7:0]  mem_wdata;
		logic        rdy_err;
		logic        rd_par;
		logic        wr_par;
		logic [7:0]  status;
		logic [7:0]  cap;
		logic        flag;
		logic        int_en;
		logic        port_en;
		logic        guard;
		logic [7:0]  rdata;
	} state_t;

	state_t s_reg;
	state_t s_next;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [3:0] pins_s;
	logic       sel_low_s;
	logic       sck_s;
	logic       sdi_s;
	logic       test_s;

	pin_sync #(
		.WIDTH   (4),
		.RST_VAL (4'h1)
	) u_sync (
		.clk  (clk),
		.rstn (rstn),
		.ce   (ce),
		.d    ({test_pin, serial_data_in_pin, serial_clock_pin, select_low_pin}),
		.q    (pins_s)
	);

	assign sel_low_s = pins_s[0];
	assign sck_s     = pins_s[1];
	assign sdi_s     = pins_s[2];
	assign test_s    = pins_s[3];

	// ------------------------------------------------------------
	// Events
	// ------------------------------------------------------------
	logic       sel_active;
	logic       start_evt;
	logic       end_evt;
	logic       sck_rise;
	logic       sck_fall;
	logic       single;
	logic       in_window;
	logic [7:0] rx_byte;
	logic [2:0] data_count;

	assign sel_active = !sel_low_s && s_reg.port_en;
	assign start_evt  = sel_active && !s_reg.act;
	assign end_evt    = !sel_active && s_reg.act;
	assign sck_rise   = sck_s && !s_reg.sck_d;
	assign sck_fall   = !sck_s && s_reg.sck_d;
	assign single     = !s_reg.multi && (s_reg.byte_cnt == 3'h1);
	assign in_window  = (s_reg.addr >= GUARD_LO) && (s_reg.addr <= GUARD_HI);
	assign rx_byte    = {s_reg.rx_sh[6:0], sdi_s};
	assign data_count = s_reg.data_ph ? (s_reg.byte_cnt - HEADER_BYTES)
	                                  : SHORT_COUNT;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_next       = s_reg;
		s_next.sck_d = sck_s;
		s_next.act   = sel_active;

		// Register read mux, other bits read zero
		s_next.rdata = 8'h00;
		if (mpu_sfr_sel) begin
			if (mpu_addr == ADDR_INT_FLAG) begin
				s_next.rdata[BIT_INT_FLAG] = s_reg.flag;
			end else if (mpu_addr == ADDR_CMD_CAP) begin
				s_next.rdata = s_reg.cap;
			end
		end else begin
			if (mpu_addr == ADDR_INT_EN) begin
				s_next.rdata[BIT_INT_EN] = s_reg.int_en;
			end else if (mpu_addr == ADDR_STATUS) begin
				s_next.rdata = s_reg.status;
			end else if (mpu_addr == ADDR_PORT_CTRL) begin
				s_next.rdata[BIT_PORT_EN] = s_reg.port_en;
				s_next.rdata[BIT_GUARD]   = s_reg.guard;
			end
		end

		// Register writes
		if (mpu_wr) begin
			if (mpu_sfr_sel) begin
				if (mpu_addr == ADDR_INT_FLAG && !mpu_wdata[BIT_INT_FLAG]) begin
					s_next.flag = 1'b0;
				end
			end else if (mpu_addr == ADDR_INT_EN) begin
				s_next.int_en = mpu_wdata[BIT_INT_EN];
			end else if (mpu_addr == ADDR_PORT_CTRL) begin
				s_next.port_en = mpu_wdata[BIT_PORT_EN];
				s_next.guard   = mpu_wdata[BIT_GUARD];
			end
		end

		// Memory answer
		if (s_reg.mem_req && mem_ack) begin
			s_next.mem_req = 1'b0;
			if (!s_reg.mem_we) begin
				s_next.rd_buf   = mem_rdata;
				s_next.rd_valid = 1'b1;
			end
		end

		if (start_evt) begin
			s_next.bit_cnt  = 3'h0;
			s_next.byte_cnt = 3'h0;
			s_next.multi    = 1'b0;
			s_next.data_ph  = 1'b0;
			s_next.rdy_err  = 1'b0;
			s_next.rd_par   = 1'b0;
			s_next.wr_par   = 1'b0;
			s_next.rd_valid = 1'b0;
			s_next.tx_sh    = 8'h00;
			s_next.tx_byte  = 8'h00;
		end else if (s_reg.act && sel_active) begin
			if (sck_rise) begin
				s_next.rx_sh   = rx_byte;
				s_next.wr_par  = s_reg.wr_par ^ sdi_s;
				s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
				if (s_reg.bit_cnt == 3'h7) begin
					s_next.byte_cnt = s_reg.byte_cnt + 3'h1;
					if (!s_reg.multi) begin
						unique case (s_reg.byte_cnt)
							3'h0: s_next.addr[15:8] = rx_byte;
							3'h1: s_next.addr[7:0]  = rx_byte;
							default: begin
								s_next.cmd   = rx_byte;
								s_next.multi = 1'b1;
								if (rx_byte[7]) begin
									s_next.rd_valid = 1'b0;
									s_next.addr     = s_reg.addr + 16'h0001;
									if (s_next.mem_req) begin
										s_next.rdy_err = 1'b1;
									end else begin
										s_next.mem_req  = 1'b1;
										s_next.mem_we   = 1'b0;
										s_next.mem_addr = s_reg.addr;
									end
								end
							end
						endcase
					end else if (!s_reg.data_ph) begin
						s_next.data_ph = 1'b1;
					end else if (!s_reg.cmd[7]) begin
						s_next.addr = s_reg.addr + 16'h0001;
						if (s_next.mem_req) begin
							s_next.rdy_err = 1'b1;
						end else if (!s_reg.guard || in_window) begin
							s_next.mem_req   = 1'b1;
							s_next.mem_we    = 1'b1;
							s_next.mem_addr  = s_reg.addr;
							s_next.mem_wdata = rx_byte;
						end
					end else begin
						// Parity only of bytes fully shifted out
						s_next.rd_par = s_reg.rd_par ^ (^s_reg.tx_byte);
					end
				end
			end else if (sck_fall) begin
				if (s_reg.bit_cnt == 3'h0 && s_reg.multi && !s_reg.data_ph) begin
					s_next.tx_sh = s_reg.status;
				end else if (s_reg.bit_cnt == 3'h0 && s_reg.data_ph && s_reg.cmd[7]) begin
					s_next.rd_valid = 1'b0;
					s_next.addr     = s_reg.addr + 16'h0001;
					if (s_reg.rd_valid) begin
						s_next.tx_sh  = s_reg.rd_buf;
						s_next.tx_byte = s_reg.rd_buf;
					end else begin
						s_next.tx_sh   = 8'h00;
						s_next.tx_byte = 8'h00;
						s_next.rdy_err = 1'b1;
					end
					if (s_next.mem_req) begin
						s_next.rdy_err = 1'b1;
					end else begin
						s_next.mem_req  = 1'b1;
						s_next.mem_we   = 1'b0;
						s_next.mem_addr = s_reg.addr;
					end
				end else begin
					s_next.tx_sh = {s_reg.tx_sh[6:0], 1'b0};
				end
			end
		end

		// Transaction end, hardware set wins over software clear
		if (end_evt) begin
			s_next.status[ST_READY_ERR]            = s_reg.rdy_err;
			s_next.status[ST_RD_PARITY]            = s_reg.rd_par;
			s_next.status[ST_WR_PARITY]            = s_reg.wr_par;
			s_next.status[ST_CNT_HI:ST_CNT_LO]     = data_count;
			s_next.status[ST_FLASH_MODE]  = flash_programming_mode && test_s;
			s_next.status[ST_FLASH_READY] = flash_programming_mode
			                                && flash_write_ready;
			if (single) begin
				s_next.cap  = s_reg.addr[15:8];
				s_next.flag = 1'b1;
			end else if (s_reg.multi && s_reg.cmd != CMD_QUIET_RD
			             && s_reg.cmd != CMD_QUIET_WR) begin
				s_next.cap  = s_reg.cmd;
				s_next.flag = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_reg         <= '0;
			s_reg.flag    <= RST_INT_FLAG;
			s_reg.int_en  <= RST_INT_EN;
			s_reg.port_en <= RST_PORT_EN;
			s_reg.guard   <= RST_GUARD;
			s_reg.status  <= RST_STATUS;
			s_reg.cap     <= RST_CMD_CAP;
			s_reg.sck_d   <= 1'b0;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign serial_data_out     = s_reg.tx_sh[7];
	assign serial_data_out_oe  = s_reg.act;
	assign shared_pins_spi_sel = s_reg.port_en;
	assign mpu_rdata           = s_reg.rdata;
	assign mpu_irq             = s_reg.flag && s_reg.int_en;
	assign mem_req             = s_reg.mem_req;
	assign mem_we              = s_reg.mem_we;
	assign mem_addr            = s_reg.mem_addr;
	assign mem_wdata           = s_reg.mem_wdata;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	irq_gating_a: assert property (ce && mpu_wr && mpu_sfr_sel && mpu_addr == ADDR_INT_FLAG
		&& !mpu_wdata[BIT_INT_FLAG] && !end_evt |=> !mpu_irq)
		else $error("irq not cleared by flag write");
	single_capture_a: assert property (ce && end_evt && single |=>
		s_reg.cap == $past(s_reg.addr[15:8]) && s_reg.flag)
		else $error("single byte not captured");
	read_quiet_a: assert property (ce && end_evt && s_reg.multi
		&& s_reg.cmd == CMD_QUIET_RD |=> $stable(s_reg.cap))
		else $error("quiet read changed capture");
	write_quiet_a: assert property (ce && end_evt && s_reg.multi
		&& s_reg.cmd == CMD_QUIET_WR && !s_reg.flag |=> !s_reg.flag)
		else $error("quiet write raised flag");
	idle_hiz_a: assert property (ce && sel_low_s |=> !serial_data_out_oe)
		else $error("output driven while idle");
	guard_window_a: assert property ($rose(mem_req) && mem_we && s_reg.guard
		|-> mem_addr >= GUARD_LO && mem_addr <= GUARD_HI)
		else $error("guarded write outside window");
	flag_clear_a: assert property ($fell(s_reg.flag) |-> $past(mpu_wr)
		&& $past(mpu_sfr_sel) && $past(mpu_addr) == ADDR_INT_FLAG)
		else $error("flag cleared without write");
	count_field_a: assert property (ce && end_evt && !s_reg.data_ph |=>
		s_reg.status[ST_CNT_HI:ST_CNT_LO] == SHORT_COUNT)
		else $error("short transaction count wrong");
	flash_gate_a: assert property (ce && end_evt && !test_s |=>
		!s_reg.status[ST_FLASH_MODE])
		else $error("flash mode bit set with test low");

	single_end_c: cover property (end_evt && single);
	read_end_c:   cover property (end_evt && s_reg.data_ph && s_reg.cmd[7]);
	write_req_c:  cover property ($rose(mem_req) && mem_we);
	ready_err_c:  cover property (end_evt && s_reg.rdy_err);

endmodule : spi_slave_transaction_port

//--- tb/spi_host_model.sv
// Host-side model of the serial link master
module spi_host_model (
	output logic      select_low_pin,
	output logic      serial_clock_pin,
	output logic      serial_data_in_pin,
	input  wire logic serial_data_out
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] rx [0:5];

	initial begin
		select_low_pin = 1'b1;
		serial_clock_pin = 1'b0;
		serial_data_in_pin = 1'b0;
	end

	// ------------------------------------------------------------
	// One frame of n bytes, clock idle low, 400 ns period
	// ------------------------------------------------------------
	task automatic frame(input logic [47:0] tx, input int n);
		select_low_pin = 1'b0;
		#400;
		for (int i = 0; i < n; i++) begin
			for (int b = 7; b >= 0; b--) begin
				serial_data_in_pin = tx[47 - 8 * i - (7 - b)];
				#200;
				serial_clock_pin = 1'b1;
				rx[i][b] = serial_data_out;
				#200;
				serial_clock_pin = 1'b0;
			end
		end
		#200;
		select_low_pin = 1'b1;
		serial_data_in_pin = ~serial_data_in_pin;
		#1000;
	endtask : frame
endmodule : spi_host_model

//--- tb/spi_slave_transaction_port_tb.sv
// Self-checking testbench for the slave serial transaction port
module spi_slave_transaction_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import spi_port_pkg::*;

	logic        clk, rstn, ce, sel_n, sck, sdi, sdo, sdo_oe, pins_sel;
	logic        test_pin, fpm, fwr, sfr, wr, irq, mem_req, mem_we, mem_ack;
	logic [15:0] addr, mem_addr;
	logic [7:0]  wdata, rdata, mem_wdata, mem_rdata, st, d;
	logic        wp, oe_seen;
	logic [7:0]  mem [logic [15:0]];
	int          fails, checks, cycles, mem_delay, mem_wait;

	spi_slave_transaction_port uut (
		.clk(clk), .rstn(rstn), .ce(ce), .select_low_pin(sel_n),
		.serial_clock_pin(sck), .serial_data_in_pin(sdi), .serial_data_out(sdo),
		.serial_data_out_oe(sdo_oe), .shared_pins_spi_sel(pins_sel), .test_pin(test_pin),
		.flash_programming_mode(fpm), .flash_write_ready(fwr), .mpu_sfr_sel(sfr),
		.mpu_addr(addr), .mpu_wr(wr), .mpu_wdata(wdata), .mpu_rdata(rdata), .mpu_irq(irq),
		.mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata)
	);

	spi_host_model host (
		.select_low_pin(sel_n), .serial_clock_pin(sck),
		.serial_data_in_pin(sdi), .serial_data_out(sdo)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Output enable seen during a frame
	always @(posedge clk) begin
		if (sdo_oe)
			oe_seen <= 1'b1;
	end

	// ------------------------------------------------------------
	// Memory responder
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (mem_req && !mem_ack && mem_wait >= mem_delay) begin
			mem_wait <= 0;
			mem_ack <= #5 1'b1;
			mem_rdata <= #5 (mem.exists(mem_addr) ? mem[mem_addr] : 8'hA5);
			if (mem_we)
				mem[mem_addr] = mem_wdata;
		end else begin
			mem_wait <= mem_req ? mem_wait + 1 : 0;
			mem_ack <= #5 1'b0;
			mem_rdata <= #5 ~mem_rdata;
		end
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic report_and_stop();
		if (fails == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic reg_wr(input logic s, input logic [15:0] a, input logic [7:0] v);
		@(posedge clk);
		#5;
		sfr = s;
		addr = a;
		wdata = v;
		wr = 1'b1;
		@(posedge clk);
		#5;
		wr = 1'b0;
	endtask : reg_wr

	task automatic rd_chk(input logic s, input logic [15:0] a, input logic [7:0] e,
			input logic [7:0] m, input string what);
		@(posedge clk);
		#5;
		sfr = s;
		addr = a;
		@(posedge clk);
		#1;
		d = rdata;
		chk(d & m, e & m, what);
	endtask : rd_chk

	task automatic send(input logic [47:0] tx, input int n);
		wp = 1'b0;
		for (int i = 0; i < n; i++)
			wp ^= ^tx[47 - 8 * i -: 8];
		host.frame(tx, n);
	endtask : send

	function automatic logic [7:0] stat(input int n, input logic rp);
		logic [2:0] c;
		c = (n > 3) ? 3'(n - 3) : SHORT_COUNT;
		return {1'b0, rp, wp, c, 2'b00};
	endfunction : stat

	task automatic cap_chk(input logic [7:0] c, input logic f);
		rd_chk(1'b1, ADDR_CMD_CAP, c, 8'hFF, "capture");
		rd_chk(1'b1, ADDR_INT_FLAG, {f, 7'h0}, 8'h80, "flag");
		chk({7'h0, irq}, {7'h0, f}, "irq");
		reg_wr(1'b1, ADDR_INT_FLAG, 8'h00);
	endtask : cap_chk

	initial begin
		cycles = 0;
		forever begin
			@(posedge clk);
			cycles++;
			if (cycles > 20000) begin
				fails++;
				report_and_stop();
			end
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{rstn, wr, sfr, test_pin, fpm, fwr, mem_ack} = '0;
		{addr, wdata, mem_rdata} = '0;
		ce = 1'b1;
		mem_delay = 2;
		mem_wait = 0;
		oe_seen = 1'b0;
		fails = 0;
		checks = 0;
		mem[16'h0410] = 8'h11;
		mem[16'h0411] = 8'h23;
		repeat (10) @(posedge clk);
		#5 rstn = 1'b1;
		rd_chk(1'b1, ADDR_INT_FLAG, 8'h00, 8'h80, "flag rst");
		rd_chk(1'b0, ADDR_INT_EN, 8'h00, 8'h80, "en rst");
		rd_chk(1'b0, ADDR_STATUS, RST_STATUS, 8'hFF, "status rst");
		rd_chk(1'b0, ADDR_PORT_CTRL, 8'h10, 8'h18, "ctrl rst");
		rd_chk(1'b0, 16'h2700, 8'h00, 8'hFF, "unmapped");
		chk({pins_sel, sdo_oe}, 8'h02, "pins idle");
		reg_wr(1'b0, ADDR_INT_EN, 8'h80);
		rd_chk(1'b0, ADDR_INT_EN, 8'h80, 8'h80, "en set");
		reg_wr(1'b1, ADDR_CMD_CAP, 8'h5A);
		rd_chk(1'b1, ADDR_CMD_CAP, RST_CMD_CAP, 8'hFF, "capture ro");
		// Write frame, two data bytes
		send(48'h0400_0500_AA55, 6);
		chk({7'h0, oe_seen}, 8'h01, "oe active");
		chk(mem[16'h0400], 8'hAA, "wr byte0");
		chk(mem[16'h0401], 8'h55, "wr byte1");
		cap_chk(8'h05, 1'b1);
		rd_chk(1'b0, ADDR_STATUS, stat(6, 1'b0), 8'hBF, "wr status");
		st = d;
		// Read frame from 0x0410
		send(48'h0410_8100_0000, 6);
		chk(host.rx[3], st, "status out");
		chk(host.rx[4], 8'h11, "rd byte0");
		chk(host.rx[5], 8'h23, "rd byte1");
		cap_chk(8'h81, 1'b1);
		rd_chk(1'b0, ADDR_STATUS, stat(6, 1'b1), 8'hFF, "rd status");
		// Quiet commands leave capture and flag alone
		send(48'h0410_8000_0000, 5);
		cap_chk(8'h81, 1'b0);
		send(48'h0410_0000_9900, 5);
		cap_chk(8'h81, 1'b0);
		chk(mem[16'h0410], 8'h99, "quiet wr");
		// Single-byte frames of 0x00 and 0x80, then two- and three-byte frames
		send(48'h0000_0000_0000, 1);
		cap_chk(8'h00, 1'b1);
		send(48'h8000_0000_0000, 1);
		cap_chk(8'h80, 1'b1);
		rd_chk(1'b0, ADDR_STATUS, stat(1, 1'b0), 8'hBF, "short count");
		send(48'h1234_0000_0000, 2);
		cap_chk(8'h80, 1'b0);
		rd_chk(1'b0, ADDR_STATUS, stat(2, 1'b0), 8'hBF, "two bytes");
		send(48'h1234_5600_0000, 3);
		cap_chk(8'h56, 1'b1);
		// Write guard window upper edge
		reg_wr(1'b0, ADDR_PORT_CTRL, 8'h18);
		send(48'h0410_0200_7700, 5);
		chk(mem[16'h0410], 8'h99, "guard out");
		send(48'h040F_0300_6600, 5);
		chk(mem[16'h040F], 8'h66, "guard in");
		cap_chk(8'h03, 1'b1);
		reg_wr(1'b0, ADDR_PORT_CTRL, 8'h10);
		// Slow memory gives a ready error
		mem_delay = 100;
		send(48'h0402_0100_4455, 6);
		rd_chk(1'b0, ADDR_STATUS, 8'h80, 8'h80, "ready err");
		mem_delay = 2;
		repeat (120) @(posedge clk);
		// Port disabled ignores the host
		reg_wr(1'b1, ADDR_INT_FLAG, 8'h00);
		reg_wr(1'b0, ADDR_PORT_CTRL, 8'h00);
		chk({7'h0, pins_sel}, 8'h00, "pins off");
		send(48'h3C00_0000_0000, 1);
		cap_chk(8'h01, 1'b0);
		reg_wr(1'b0, ADDR_PORT_CTRL, 8'h10);
		// Flash mode status bits
		reg_wr(1'b1, ADDR_INT_FLAG, 8'h80);
		rd_chk(1'b1, ADDR_INT_FLAG, 8'h00, 8'h80, "flag set ign");
		{test_pin, fpm, fwr} = 3'b111;
		send(48'h1234_0000_0000, 2);
		rd_chk(1'b0, ADDR_STATUS, 8'h03, 8'h03, "flash bits");
		test_pin = 1'b0;
		send(48'h1234_0000_0000, 2);
		rd_chk(1'b0, ADDR_STATUS, 8'h00, 8'h02, "test low");
		report_and_stop();
	end
endmodule : spi_slave_transaction_port_tb
